// ===== design/prc_top.v
// Functional notes
// - form 0 is first-order smoothing, 1 second-order, taken at restart.
// - time constant 0 to 32767 in 0.1 ms, default 0, applied only after reissue and clear.
// - smoothing keeps the pulse count and changes only timing.
// - a new time constant acts after a reissued reference and an error clear.
// - error is reference received minus motor travel; in-position needs it below the window.
// - in-window must outlast settle time 0 to 60000 in 0.1 ms, default 500, live.
// - window 0 to 5000, default 10, live.
// - in-position output low when complete, high when not.
// - in speed control the output shows speed match.
// - the indication goes to the terminal chosen by the assign setting.
// - inhibited reference pulses are neither counted nor passed.
// - inhibit exists only in mode B, taken at restart.
// - in mode B without the gear use switch low stops counting, high resumes.
// - in the gear use of mode B switch low selects the second numerator.
`timescale 1ns/1ps
`include "prc_map.vh"
`default_nettype none
module prc_top #(
    parameter TICK_CYCLES = `PRC_TICK_NS / `PRC_CLK_PERIOD_NS,
    parameter TERMS = 4
) (
    input wire MCLK_IN,
    input wire RESET_IN,
    input wire [`PRC_ADDR_W-1:0] ADDR_IN,
    input wire [31:0] WR_DATA_IN,
    input wire WR_IN,
    input wire RD_IN,
    output reg [31:0] RD_DATA_OUT,
    output wire IRQ_OUT,
    input wire REF_PULSE_IN,
    input wire REF_DIR_IN,
    input wire MODE_SWITCH_N_IN,
    input wire ERROR_CLEAR_IN,
    input wire MOTOR_PULSE_IN,
    input wire MOTOR_DIR_IN,
    input wire SPEED_MATCH_IN,
    output wire POS_PULSE_OUT,
    output wire POS_DIR_OUT,
    output reg GEAR2_SEL_OUT,
    output reg IN_POSITION_N_OUT,
    output reg [TERMS-1:0] TERM_N_OUT
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    reg [3:0] mode_pend_reg;
    reg form_pend_reg;
    reg gearuse_pend_reg;
    reg [3:0] mode_act_reg;
    reg form_act_reg;
    reg gearuse_act_reg;
    reg [14:0] tc_reg;
    reg [14:0] tc_act_reg;
    reg tc_changed_reg;
    reg tc_reissued_reg;
    reg [12:0] window_reg;
    reg [15:0] settle_reg;
    reg [1:0] term_reg;
    reg [`PRC_EV_W-1:0] status_reg;
    reg [`PRC_EV_W-1:0] status_next;
    reg [`PRC_EV_W-1:0] mask_reg;
    reg [`PRC_EV_W-1:0] events;
    reg signed [31:0] err_reg;
    reg [31:0] settle_cnt_reg;
    reg in_pos_reg;
    reg [2:0] pin_prev_reg;
    reg [31:0] rd_next;
    wire [5:0] pins_sync;
    wire ref_lvl;
    wire ref_dir;
    wire switch_n;
    wire clr_lvl;
    wire mot_lvl;
    wire mot_dir;
    wire ref_edge;
    wire mot_edge;
    wire clr_edge;
    wire inhibit;
    wire ref_taken;
    wire [31:0] tc_cycles;
    wire [31:0] settle_cycles;
    wire [31:0] err_abs;
    wire in_window;
    wire in_pos_now;
    wire s1_step;
    wire s1_dir;
    wire s2_step;
    wire s2_dir;
    wire wr_ctrl;

    // ----------------------------------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------------------------------
    prc_sync #(.W(6)) u_sync (
        .clk_in(MCLK_IN),
        .rst_in(RESET_IN),
        .d_in({MOTOR_DIR_IN, MOTOR_PULSE_IN, ERROR_CLEAR_IN, MODE_SWITCH_N_IN, REF_DIR_IN, REF_PULSE_IN}),
        .q_out(pins_sync)
    );

    assign ref_lvl = pins_sync[0];
    assign ref_dir = pins_sync[1];
    assign switch_n = pins_sync[2];
    assign clr_lvl = pins_sync[3];
    assign mot_lvl = pins_sync[4];
    assign mot_dir = pins_sync[5];

    // previous levels for rising-edge detection
    always @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            pin_prev_reg <= 3'h0;
        end else begin
            pin_prev_reg <= {mot_lvl, clr_lvl, ref_lvl};
        end
    end

    assign ref_edge = ref_lvl & ~pin_prev_reg[0];
    assign clr_edge = clr_lvl & ~pin_prev_reg[1];
    assign mot_edge = mot_lvl & ~pin_prev_reg[2];

    // ----------------------------------------------------------------
    // mode decode and pulse inhibit
    // ----------------------------------------------------------------
    assign inhibit = (mode_act_reg == `PRC_MODE_INHIBIT) && !gearuse_act_reg && !switch_n;
    assign ref_taken = ref_edge && !inhibit;

    // gear numerator choice in the alternative use of mode b
    always @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            GEAR2_SEL_OUT <= 1'b0;
        end else begin
            GEAR2_SEL_OUT <= (mode_act_reg == `PRC_MODE_INHIBIT) && gearuse_act_reg && !switch_n;
        end
    end

    // ----------------------------------------------------------------
    // smoothing chain
    // ----------------------------------------------------------------
    assign tc_cycles = {17'h00000, tc_act_reg} * TICK_CYCLES;

    prc_smooth u_stage1 (
        .clk_in(MCLK_IN),
        .rst_in(RESET_IN),
        .step_in(ref_taken),
        .dir_in(ref_dir),
        .period_in(tc_cycles),
        .step_out(s1_step),
        .dir_out(s1_dir),
        .busy_out()
    );

    prc_smooth u_stage2 (
        .clk_in(MCLK_IN),
        .rst_in(RESET_IN),
        .step_in(s1_step),
        .dir_in(s1_dir),
        .period_in(tc_cycles),
        .step_out(s2_step),
        .dir_out(s2_dir),
        .busy_out()
    );

    // second stage only used for the second-order form
    assign POS_PULSE_OUT = form_act_reg ? s2_step : s1_step;
    assign POS_DIR_OUT = form_act_reg ? s2_dir : s1_dir;

    // time constant takes effect after reissue then clear
    always @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            tc_act_reg <= `PRC_TC_RST;
            tc_reissued_reg <= 1'b0;
        end else begin
            if (tc_changed_reg && ref_taken) begin
                tc_reissued_reg <= 1'b1;
            end
            if (clr_edge && tc_reissued_reg) begin
                tc_act_reg <= tc_reg;
                tc_reissued_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // position error and in-position detection
    // ----------------------------------------------------------------
    always @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            err_reg <= 32'sh0;
        end else if (clr_edge) begin
            err_reg <= 32'sh0;
        end else begin
            // reference received minus motor travel
            err_reg <= err_reg + (ref_taken ? (ref_dir ? 32'sh1 : -32'sh1) : 32'sh0)
                - (mot_edge ? (mot_dir ? 32'sh1 : -32'sh1) : 32'sh0);
        end
    end

    assign err_abs = err_reg[31] ? (~err_reg + 32'h1) : err_reg;
    assign in_window = err_abs < {19'h00000, window_reg};
    assign settle_cycles = {16'h0000, settle_reg} * TICK_CYCLES;
    assign in_pos_now = in_window && (settle_cnt_reg > settle_cycles);

    // settle counter runs while in window, saturates
    always @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            settle_cnt_reg <= 32'h0;
        end else if (!in_window) begin
            settle_cnt_reg <= 32'h0;
        end else if (settle_cnt_reg != 32'hffffffff) begin
            settle_cnt_reg <= settle_cnt_reg + 32'h1;
        end
    end

    // active-low output and terminal routing
    always @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            in_pos_reg <= 1'b0;
            IN_POSITION_N_OUT <= 1'b1;
            TERM_N_OUT <= {TERMS{1'b1}};
        end else begin
            in_pos_reg <= in_pos_now;
            if (mode_act_reg == `PRC_MODE_SPEED) begin
                IN_POSITION_N_OUT <= ~SPEED_MATCH_IN;
            end else begin
                IN_POSITION_N_OUT <= ~in_pos_now;
            end
            TERM_N_OUT <= {TERMS{1'b1}};
            TERM_N_OUT[term_reg] <= (mode_act_reg == `PRC_MODE_SPEED) ? ~SPEED_MATCH_IN : ~in_pos_now;
        end
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    assign wr_ctrl = WR_IN && (ADDR_IN == `PRC_A_CTRL);

    // settings, restart copies pending mode and form
    always @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            mode_pend_reg <= `PRC_MODE_POS;
            form_pend_reg <= `PRC_FORM_RST;
            gearuse_pend_reg <= 1'b0;
            mode_act_reg <= `PRC_MODE_POS;
            form_act_reg <= `PRC_FORM_RST;
            gearuse_act_reg <= 1'b0;
            tc_reg <= `PRC_TC_RST;
            tc_changed_reg <= 1'b0;
            window_reg <= `PRC_WINDOW_RST;
            settle_reg <= `PRC_SETTLE_RST;
            term_reg <= `PRC_TERM_RST;
            mask_reg <= {`PRC_EV_W{1'b0}};
        end else begin
            if (clr_edge && tc_reissued_reg) begin
                tc_changed_reg <= 1'b0;
            end
            if (wr_ctrl) begin
                mode_pend_reg <= WR_DATA_IN[`PRC_CTRL_MODE];
                form_pend_reg <= WR_DATA_IN[`PRC_CTRL_FORM];
                gearuse_pend_reg <= WR_DATA_IN[`PRC_CTRL_GEARUSE];
                if (WR_DATA_IN[`PRC_CTRL_RESTART]) begin
                    mode_act_reg <= WR_DATA_IN[`PRC_CTRL_MODE];
                    form_act_reg <= WR_DATA_IN[`PRC_CTRL_FORM];
                    gearuse_act_reg <= WR_DATA_IN[`PRC_CTRL_GEARUSE];
                end
            end else if (WR_IN && (ADDR_IN == `PRC_A_TC)) begin
                tc_reg <= WR_DATA_IN[`PRC_TC_F];
                tc_changed_reg <= 1'b1;
            end else if (WR_IN && (ADDR_IN == `PRC_A_WINDOW)) begin
                if (WR_DATA_IN[31:0] > {19'h00000, `PRC_WINDOW_MAX}) begin
                    window_reg <= `PRC_WINDOW_MAX;
                end else begin
                    window_reg <= WR_DATA_IN[`PRC_WIN_F];
                end
            end else if (WR_IN && (ADDR_IN == `PRC_A_SETTLE)) begin
                if (WR_DATA_IN[31:0] > {16'h0000, `PRC_SETTLE_MAX}) begin
                    settle_reg <= `PRC_SETTLE_MAX;
                end else begin
                    settle_reg <= WR_DATA_IN[`PRC_SET_F];
                end
            end else if (WR_IN && (ADDR_IN == `PRC_A_TERM)) begin
                term_reg <= WR_DATA_IN[`PRC_TERM_F];
            end else if (WR_IN && (ADDR_IN == `PRC_A_MASK)) begin
                mask_reg <= WR_DATA_IN[`PRC_EV_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // events, sticky status and interrupt
    // ----------------------------------------------------------------
    always @* begin
        events = {`PRC_EV_W{1'b0}};
        events[`PRC_EV_REACH] = in_pos_now && !in_pos_reg;
        events[`PRC_EV_LOST] = !in_pos_now && in_pos_reg;
        events[`PRC_EV_IGNORED] = ref_edge && inhibit;
        events[`PRC_EV_CLEARED] = clr_edge;
        status_next = status_reg;
        if (RD_IN && (ADDR_IN == `PRC_A_STATUS)) begin
            status_next = {`PRC_EV_W{1'b0}};
        end
        status_next = status_next | events; // set wins over read clear
    end

    always @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            status_reg <= {`PRC_EV_W{1'b0}};
        end else begin
            status_reg <= status_next;
        end
    end

    assign IRQ_OUT = |(status_reg & mask_reg);

    // ----------------------------------------------------------------
    // register reads, data one cycle after the strobe
    // ----------------------------------------------------------------
    always @* begin
        rd_next = 32'h00000000;
        if (ADDR_IN == `PRC_A_CTRL) begin
            rd_next[`PRC_CTRL_MODE] = mode_pend_reg;
            rd_next[`PRC_CTRL_FORM] = form_pend_reg;
            rd_next[`PRC_CTRL_GEARUSE] = gearuse_pend_reg;
        end else if (ADDR_IN == `PRC_A_TC) begin
            rd_next[`PRC_TC_F] = tc_reg;
        end else if (ADDR_IN == `PRC_A_WINDOW) begin
            rd_next[`PRC_WIN_F] = window_reg;
        end else if (ADDR_IN == `PRC_A_SETTLE) begin
            rd_next[`PRC_SET_F] = settle_reg;
        end else if (ADDR_IN == `PRC_A_TERM) begin
            rd_next[`PRC_TERM_F] = term_reg;
        end else if (ADDR_IN == `PRC_A_STATUS) begin
            rd_next[`PRC_EV_W-1:0] = status_reg;
        end else if (ADDR_IN == `PRC_A_MASK) begin
            rd_next[`PRC_EV_W-1:0] = mask_reg;
        end else if (ADDR_IN == `PRC_A_POSERR) begin
            rd_next = err_reg;
        end else if (ADDR_IN == `PRC_A_STATE) begin
            rd_next[`PRC_CTRL_MODE] = mode_act_reg;
            rd_next[`PRC_CTRL_FORM] = form_act_reg;
            rd_next[`PRC_CTRL_GEARUSE] = gearuse_act_reg;
            rd_next[8] = inhibit;
            rd_next[9] = in_pos_reg;
            rd_next[10] = tc_changed_reg;
            rd_next[26:12] = tc_act_reg;
        end
    end

    always @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            RD_DATA_OUT <= 32'h00000000;
        end else if (RD_IN) begin
            RD_DATA_OUT <= rd_next;
        end else begin
            RD_DATA_OUT <= 32'h00000000;
        end
    end
endmodule // prc_top
`default_nettype wire

// ===== pkg/prc_map.vh
`ifndef PRC_MAP_VH
`define PRC_MAP_VH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PRC_CLK_PERIOD_NS 8
`define PRC_TICK_NS 100000
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define PRC_ADDR_W 8
`define PRC_A_CTRL 8'h00
`define PRC_A_TC 8'h04
`define PRC_A_WINDOW 8'h08
`define PRC_A_SETTLE 8'h0c
`define PRC_A_TERM 8'h10
`define PRC_A_STATUS 8'h14
`define PRC_A_MASK 8'h18
`define PRC_A_POSERR 8'h1c
`define PRC_A_STATE 8'h20
// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define PRC_CTRL_MODE 3:0
`define PRC_CTRL_FORM 4
`define PRC_CTRL_GEARUSE 5
`define PRC_CTRL_RESTART 8
`define PRC_TC_F 14:0
`define PRC_WIN_F 12:0
`define PRC_SET_F 15:0
`define PRC_TERM_F 1:0
`define PRC_EV_REACH 0
`define PRC_EV_LOST 1
`define PRC_EV_IGNORED 2
`define PRC_EV_CLEARED 3
`define PRC_EV_W 4
// ----------------------------------------------------------------
// modes, reset values and limits
// ----------------------------------------------------------------
`define PRC_MODE_POS 4'h0
`define PRC_MODE_SPEED 4'h1
`define PRC_MODE_INHIBIT 4'hb
`define PRC_FORM_RST 1'b0
`define PRC_TC_RST 15'h0000
`define PRC_WINDOW_RST 13'h000a
`define PRC_WINDOW_MAX 13'h1388
`define PRC_SETTLE_RST 16'h01f4
`define PRC_SETTLE_MAX 16'hea60
`define PRC_TERM_RST 2'h0
`endif

// ===== design/prc_sync.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// two-stage synchroniser for pin inputs
// ----------------------------------------------------------------
module prc_sync #(
    parameter W = 1
) (
    input wire clk_in,
    input wire rst_in,
    input wire [W-1:0] d_in,
    output reg [W-1:0] q_out
);
    reg [W-1:0] meta_reg;

    // first stage feeds only the second
    always @(posedge clk_in) begin
        if (rst_in) begin
            meta_reg <= {W{1'b0}};
            q_out <= {W{1'b0}};
        end else begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
endmodule // prc_sync
`default_nettype wire

// ===== design/prc_smooth.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// one first-order smoothing stage, count preserving
// ----------------------------------------------------------------
module prc_smooth #(
    parameter CW = 32,
    parameter BW = 24
) (
    input wire clk_in,
    input wire rst_in,
    input wire step_in,
    input wire dir_in,
    input wire [CW-1:0] period_in,
    output reg step_out,
    output reg dir_out,
    output wire busy_out
);
    reg signed [BW-1:0] backlog_reg;
    reg [CW:0] acc_reg;
    reg signed [BW-1:0] backlog_next;
    reg [CW:0] acc_next;
    reg [CW:0] acc_sum;
    reg [BW-1:0] mag;
    reg fire;
    reg pass;

    assign busy_out = (backlog_reg != {BW{1'b0}});

    // backlog drains at a rate proportional to its size (exponential)
    always @* begin
        mag = backlog_reg[BW-1] ? (~backlog_reg + 1'b1) : backlog_reg;
        acc_sum = acc_reg + {{(CW+1-BW){1'b0}}, mag};
        pass = (period_in == {CW{1'b0}}) && !busy_out && step_in;
        fire = busy_out && ((period_in == {CW{1'b0}}) || (acc_sum >= {1'b0, period_in}));
        backlog_next = backlog_reg;
        if (step_in && !pass) begin
            backlog_next = dir_in ? backlog_next + 1'b1 : backlog_next - 1'b1;
        end
        if (fire) begin
            backlog_next = backlog_reg[BW-1] ? backlog_next + 1'b1 : backlog_next - 1'b1;
        end
        if (!busy_out) begin
            acc_next = {(CW+1){1'b0}};
        end else if (fire) begin
            acc_next = acc_sum - {1'b0, period_in};
            if (acc_next > {1'b0, period_in}) begin
                acc_next = {1'b0, period_in}; // bound runaway accumulation
            end
        end else begin
            acc_next = acc_sum;
        end
    end

    // state and registered pulse output
    always @(posedge clk_in) begin
        if (rst_in) begin
            backlog_reg <= {BW{1'b0}};
            acc_reg <= {(CW+1){1'b0}};
            step_out <= 1'b0;
            dir_out <= 1'b0;
        end else begin
            backlog_reg <= backlog_next;
            acc_reg <= acc_next;
            step_out <= pass | fire;
            if (pass) begin
                dir_out <= dir_in;
            end else if (fire) begin
                dir_out <= ~backlog_reg[BW-1];
            end
        end
    end
endmodule // prc_smooth
`default_nettype wire

// ===== tb/prc_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "prc_map.vh"
// ----------------------------------------------------------------
// port checker for the position reference block
// ----------------------------------------------------------------
module prc_props #(
    parameter TERMS = 4
) (
    input wire MCLK_IN,
    input wire RESET_IN,
    input wire [7:0] ADDR_IN,
    input wire [31:0] WR_DATA_IN,
    input wire WR_IN,
    input wire RD_IN,
    input wire [31:0] RD_DATA_OUT,
    input wire IRQ_OUT,
    input wire MODE_SWITCH_N_IN,
    input wire SPEED_MATCH_IN,
    input wire GEAR2_SEL_OUT,
    input wire IN_POSITION_N_OUT,
    input wire [TERMS-1:0] TERM_N_OUT
);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (RESET_IN);
    reg spd_reg, gear_reg, mask_reg;
    // tracks the restarted mode and whether a mask bit was ever set
    always @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            spd_reg <= 1'b0;
            gear_reg <= 1'b0;
            mask_reg <= 1'b0;
        end else begin
            if (WR_IN && ADDR_IN == `PRC_A_CTRL && WR_DATA_IN[8]) begin
                spd_reg <= WR_DATA_IN[3:0] == `PRC_MODE_SPEED;
                gear_reg <= WR_DATA_IN[3:0] == `PRC_MODE_INHIBIT && WR_DATA_IN[5];
            end
            if (WR_IN && ADDR_IN == `PRC_A_MASK && |WR_DATA_IN[3:0])
                mask_reg <= 1'b1;
        end
    end
    a_read_idle: assert property (!$past(RD_IN) |-> RD_DATA_OUT == 32'h0)
        else $error("stray read data");
    a_unmapped_zero: assert property (RD_IN && ADDR_IN == 8'h24 |=> RD_DATA_OUT == 32'h0)
        else $error("unmapped read not zero");
    a_window_clamp: assert property (
        (WR_IN && ADDR_IN == `PRC_A_WINDOW) ##1 (RD_IN && ADDR_IN == `PRC_A_WINDOW) |=>
        RD_DATA_OUT[12:0] == (($past(WR_DATA_IN, 2) > 32'h1388) ? 13'h1388 : $past(WR_DATA_IN[12:0], 2)))
        else $error("window readback");
    a_irq_masked: assert property (!mask_reg |-> !IRQ_OUT)
        else $error("masked irq");
    a_term_single: assert property ($countones(~TERM_N_OUT) <= 1)
        else $error("two terminals");
    a_inpos_routed: assert property (!IN_POSITION_N_OUT |-> ##[0:1] !(&TERM_N_OUT))
        else $error("no terminal");
    a_speed_match: assert property (
        (spd_reg && $stable(SPEED_MATCH_IN)) [*3] |-> IN_POSITION_N_OUT == !SPEED_MATCH_IN)
        else $error("speed match");
    a_gear_select: assert property ((gear_reg && !MODE_SWITCH_N_IN) [*5] |-> GEAR2_SEL_OUT)
        else $error("second gear");
endmodule // prc_props
`default_nettype wire

// ===== tb/prc_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// host controller model: reference pulses, clear and mode switch
// ----------------------------------------------------------------
module prc_host (
    input wire logic clk_in,
    output var logic ref_pulse_out,
    output var logic ref_dir_out,
    output var logic switch_n_out,
    output var logic clear_out,
    output var logic motor_pulse_out,
    output var logic motor_dir_out
);
    // idle pin levels from time zero
    initial begin
        ref_pulse_out = 1'b0;
        ref_dir_out = 1'b1;
        switch_n_out = 1'b1;
        clear_out = 1'b0;
        motor_pulse_out = 1'b0;
        motor_dir_out = 1'b1;
    end
    // n pulses, two clocks high and two low; motor picks the feedback pins
    task automatic pulses(input int n, input logic dir, input logic motor);
        repeat (n) begin
            if (motor) begin
                motor_dir_out <= dir;
                motor_pulse_out <= 1'b1;
            end else begin
                ref_dir_out <= dir;
                ref_pulse_out <= 1'b1;
            end
            repeat (2) @(posedge clk_in);
            motor_pulse_out <= 1'b0;
            ref_pulse_out <= 1'b0;
            repeat (2) @(posedge clk_in);
        end
    endtask
    // error clear after a re-issued reference loads a new time constant
    task automatic clear_error();
        clear_out <= 1'b1;
        repeat (3) @(posedge clk_in);
        clear_out <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask
    // mode switch level, held long enough to pass the synchroniser
    task automatic set_switch(input logic lvl);
        switch_n_out <= lvl;
        repeat (6) @(posedge clk_in);
    endtask
endmodule // prc_host
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "prc_map.vh"
module tb;
    logic clk, rst, wr, rd, spd;
    logic [7:0] addr;
    logic [31:0] wdata, rd_q;
    wire [31:0] rdata;
    wire [3:0] term_n;
    wire irq, pos_p, pos_d, gear2, in_pos_n, ref_p, ref_d, sw_n, clr, mot_p, mot_d;
    int num_errors = 0, n_checks = 0, pulse_cnt = 0;
    prc_top #(.TICK_CYCLES(4)) dut (.MCLK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr), .WR_DATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RD_DATA_OUT(rdata), .IRQ_OUT(irq), .REF_PULSE_IN(ref_p), .REF_DIR_IN(ref_d),
        .MODE_SWITCH_N_IN(sw_n), .ERROR_CLEAR_IN(clr), .MOTOR_PULSE_IN(mot_p), .MOTOR_DIR_IN(mot_d),
        .SPEED_MATCH_IN(spd), .POS_PULSE_OUT(pos_p), .POS_DIR_OUT(pos_d), .GEAR2_SEL_OUT(gear2),
        .IN_POSITION_N_OUT(in_pos_n), .TERM_N_OUT(term_n));
    prc_host host (.clk_in(clk), .ref_pulse_out(ref_p), .ref_dir_out(ref_d), .switch_n_out(sw_n),
        .clear_out(clr), .motor_pulse_out(mot_p), .motor_dir_out(mot_d));
    // clock at 125 MHz
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // net pulse count handed to the position loop
    always @(posedge clk) begin
        if (!rst && pos_p === 1'b1)
            pulse_cnt <= pulse_cnt + (pos_d ? 1 : -1);
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        rd_q = rdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        rd_reg(a);
        chk(rd_q, exp, what);
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic t_defaults();
        chk(in_pos_n, 32'h1, "idle inpos");
        chk(term_n, 32'hf, "idle term");
        rd_chk(`PRC_A_TC, 32'h0, "tc");
        rd_chk(`PRC_A_WINDOW, 32'ha, "window");
        rd_chk(`PRC_A_SETTLE, 32'h1f4, "settle");
        rd_reg(`PRC_A_STATE);
        chk(rd_q[4:0], 32'h0, "mode");
        rd_chk(8'h24, 32'h0, "unmapped");
    endtask
    task automatic t_position();
        int c0;
        wr_reg(`PRC_A_WINDOW, 32'h2);
        wait_clk(1);
        wr_reg(`PRC_A_SETTLE, 32'h14);
        c0 = pulse_cnt;
        host.pulses(5, 1'b1, 1'b0);
        wait_clk(10);
        chk(pulse_cnt - c0, 32'h5, "passed");
        rd_chk(`PRC_A_POSERR, 32'h5, "error");
        chk(in_pos_n, 32'h1, "outside");
        host.pulses(5, 1'b1, 1'b1);
        wait_clk(40);
        chk(in_pos_n, 32'h1, "settling");
        wait_clk(80);
        chk(in_pos_n, 32'h0, "settled");
        chk(term_n, 32'he, "term 0");
        wr_reg(`PRC_A_TERM, 32'h2);
        wait_clk(3);
        chk(term_n, 32'hb, "term 2");
        chk(irq, 32'h0, "masked");
        wr_reg(`PRC_A_MASK, 32'h1);
        wait_clk(1);
        chk(irq, 32'h1, "unmasked");
        rd_reg(`PRC_A_STATUS);
        chk(rd_q[0], 32'h1, "reach");
        rd_chk(`PRC_A_STATUS, 32'h0, "read clear");
        chk(irq, 32'h0, "irq clear");
        wr_reg(`PRC_A_WINDOW, 32'h1770);
        rd_chk(`PRC_A_WINDOW, 32'h1388, "win clamp");
        wr_reg(`PRC_A_SETTLE, 32'h11170);
        rd_chk(`PRC_A_SETTLE, 32'hea60, "set clamp");
        wr_reg(`PRC_A_WINDOW, 32'h2);
    endtask
    task automatic t_inhibit();
        int c0;
        wr_reg(`PRC_A_CTRL, 32'h100);
        host.set_switch(1'b0);
        c0 = pulse_cnt;
        host.pulses(1, 1'b1, 1'b0);
        wait_clk(8);
        chk(pulse_cnt - c0, 32'h1, "mode 0");
        wr_reg(`PRC_A_CTRL, 32'h10b);
        wait_clk(4);
        c0 = pulse_cnt;
        host.pulses(3, 1'b1, 1'b0);
        wait_clk(8);
        chk(pulse_cnt - c0, 32'h0, "inhibited");
        rd_reg(`PRC_A_STATUS);
        chk(rd_q[2], 32'h1, "ignored");
        host.set_switch(1'b1);
        host.pulses(2, 1'b0, 1'b0);
        wait_clk(8);
        chk(pulse_cnt - c0, 32'hfffffffe, "resumed");
    endtask
    task automatic t_modes();
        wr_reg(`PRC_A_CTRL, 32'h12b);
        host.set_switch(1'b0);
        chk(gear2, 32'h1, "second gear");
        host.set_switch(1'b1);
        chk(gear2, 32'h0, "first gear");
        wr_reg(`PRC_A_CTRL, 32'h101);
        spd <= 1'b1;
        wait_clk(3);
        chk(in_pos_n, 32'h0, "match");
        spd <= 1'b0;
        wait_clk(3);
        chk(in_pos_n, 32'h1, "mismatch");
    endtask
    task automatic t_smooth();
        int c0;
        for (int f = 0; f < 2; f++) begin
            wr_reg(`PRC_A_CTRL, 32'h100 | (f << 4));
            wait_clk(1);
            wr_reg(`PRC_A_TC, 32'h64);
            host.pulses(1, 1'b1, 1'b0);
            host.clear_error();
            wait_clk(3000);
            c0 = pulse_cnt;
            host.pulses(6, 1'b1, 1'b0);
            chk(pulse_cnt - c0 < 6, 32'h1, "held back");
            wait_clk(6000);
            chk(pulse_cnt - c0, 32'h6, "count kept");
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // reset, then the scenarios in turn
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h0;
        wdata = 32'h0;
        spd = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_defaults();
        t_position();
        t_inhibit();
        t_modes();
        t_smooth();
        stop_test();
    end
    // watchdog well beyond the expected run
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        stop_test();
    end
endmodule // tb
bind prc_top prc_props #(.TERMS(TERMS)) props (.MCLK_IN, .RESET_IN, .ADDR_IN, .WR_DATA_IN, .WR_IN, .RD_IN,
    .RD_DATA_OUT, .IRQ_OUT, .MODE_SWITCH_N_IN, .SPEED_MATCH_IN, .GEAR2_SEL_OUT, .IN_POSITION_N_OUT, .TERM_N_OUT);
`default_nettype wire
